// File: shared/ccpt_pkg.sv
// Shared constants for the capture/compare block and its period timer.
package ccpt_pkg;
  localparam int CH_N = 2;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam int CNT_W = 16;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_PORT_DATA = 8'h07;
  localparam logic [7:0] IDX_FLAGS1 = 8'h0c;
  localparam logic [7:0] IDX_FLAGS2 = 8'h0d;
  localparam logic [7:0] IDX_CNT_L = 8'h0e;
  localparam logic [7:0] IDX_CNT_H = 8'h0f;
  localparam logic [7:0] IDX_PCOUNT = 8'h11;
  localparam logic [7:0] IDX_PCTRL = 8'h12;
  localparam logic [7:0] IDX_V1L = 8'h15;
  localparam logic [7:0] IDX_V1H = 8'h16;
  localparam logic [7:0] IDX_C1 = 8'h17;
  localparam logic [7:0] IDX_V2L = 8'h1b;
  localparam logic [7:0] IDX_V2H = 8'h1c;
  localparam logic [7:0] IDX_C2 = 8'h1d;
  localparam logic [7:0] IDX_PORT_DIR = 8'h87;
  localparam logic [7:0] IDX_ENA1 = 8'h8c;
  localparam logic [7:0] IDX_ENA2 = 8'h8d;
  localparam logic [7:0] IDX_LIMIT = 8'h92;
  // Reset values.
  localparam logic [7:0] LIMIT_RST = 8'hff;
  localparam logic [7:0] DIR_RST = 8'hff;
  // Field positions.
  localparam int PS_LSB = 3;
  localparam int PS_MSB = 6;
  localparam int RUN_BIT = 2;
  localparam int CKPS_LSB = 0;
  localparam int CKPS_MSB = 1;
  localparam int PCTRL_W = 7;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;
  localparam int DUTY_LSB = 4;
  localparam int DUTY_MSB = 5;
  localparam int CTRL_W = 6;
  localparam int FLG_CH1 = 2;
  localparam int FLG_TMR = 1;
  localparam int FLG_CH2 = 0;
  localparam int PIN_CH1 = 2;
  localparam int PIN_CH2 = 1;
  // Channel modes and mode groups (upper two mode bits).
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] CAP_FALL = 4'h4;
  localparam logic [3:0] CAP_4TH = 4'h6;
  localparam logic [3:0] CAP_16TH = 4'h7;
  localparam logic [3:0] CMP_SET = 4'h8;
  localparam logic [3:0] CMP_CLR = 4'h9;
  localparam logic [3:0] CMP_TRIG = 4'hb;
  localparam logic [1:0] GRP_CAP = 2'b01;
  localparam logic [1:0] GRP_CMP = 2'b10;
  localparam logic [1:0] GRP_PWM = 2'b11;
  // Prescale select codes, then prescale and capture counts held as the count minus one.
  localparam logic [1:0] CKPS_DIV1 = 2'b00;
  localparam logic [1:0] CKPS_DIV4 = 2'b01;
  localparam logic [3:0] PRE_DIV1_M1 = 4'h0;
  localparam logic [3:0] PRE_DIV4_M1 = 4'h3;
  localparam logic [3:0] PRE_DIV16_M1 = 4'hf;
  localparam logic [3:0] CAP_EACH_M1 = 4'h0;
  localparam logic [3:0] CAP_4TH_M1 = 4'h3;
  localparam logic [3:0] CAP_16TH_M1 = 4'hf;
endpackage : ccpt_pkg

// File: logic/ccpt_channel.sv
// One capture/compare/PWM channel working against shared time bases.
`timescale 1ns/1ps
`default_nettype none
module ccpt_channel (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Configuration.
  input wire logic [3:0] mode_i,
  input wire logic [9:0] duty_i,
  input wire logic [ccpt_pkg::CNT_W-1:0] value_i,
  // Time bases and event source.
  input wire logic [ccpt_pkg::CNT_W-1:0] count_i,
  input wire logic evt_lvl_i,
  input wire logic pwm_start_i,
  input wire logic [9:0] pwm_pos_i,
  // Results.
  output logic capture_o,
  output logic match_o,
  output logic trig_o,
  output logic out_o
);
  import ccpt_pkg::*;

  logic lvl_prev_reg;
  logic match_prev_reg;
  logic out_reg;
  logic out_next;
  logic [3:0] cap_cnt_reg;
  logic [3:0] cap_cnt_next;
  logic [9:0] duty_reg;

  wire is_cap = (mode_i[3:2] == GRP_CAP);
  wire is_cmp = (mode_i[3:2] == GRP_CMP);
  wire is_pwm = (mode_i[3:2] == GRP_PWM);
  wire rise = evt_lvl_i & ~lvl_prev_reg;
  wire fall = ~evt_lvl_i & lvl_prev_reg;
  wire edge_sel = (mode_i == CAP_FALL) ? fall : rise;
  wire [3:0] cap_need = (mode_i == CAP_4TH) ? CAP_4TH_M1 :
    (mode_i == CAP_16TH) ? CAP_16TH_M1 : CAP_EACH_M1;
  wire cap_hit = is_cap & edge_sel & (cap_cnt_reg == cap_need);
  // Matching is edge based so a stopped counter cannot flag twice.
  wire cmp_hit = is_cmp & (count_i == value_i) & ~match_prev_reg;

  assign capture_o = cap_hit;
  assign match_o = cmp_hit;
  assign trig_o = cmp_hit & (mode_i == CMP_TRIG);
  assign out_o = out_reg;

  always_comb
  begin
    cap_cnt_next = cap_cnt_reg;
    if (!is_cap)
      cap_cnt_next = '0;
    else if (edge_sel)
      cap_cnt_next = cap_hit ? '0 : cap_cnt_reg + 4'h1;
  end

  always_comb
  begin
    out_next = out_reg;
    if (mode_i == MODE_OFF)
      out_next = 1'b0;
    else if (cmp_hit && mode_i == CMP_SET)
      out_next = 1'b1;
    else if (cmp_hit && mode_i == CMP_CLR)
      out_next = 1'b0;
    else if (is_pwm && pwm_start_i)
      out_next = (duty_i != '0);
    else if (is_pwm && pwm_pos_i >= duty_reg)
      out_next = 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      lvl_prev_reg <= 1'b0;
      match_prev_reg <= 1'b0;
      out_reg <= 1'b0;
      cap_cnt_reg <= '0;
      duty_reg <= '0;
    end
    else
    begin
      lvl_prev_reg <= evt_lvl_i;
      match_prev_reg <= is_cmp & (count_i == value_i);
      out_reg <= out_next;
      cap_cnt_reg <= cap_cnt_next;
      if (pwm_start_i)
        duty_reg <= duty_i;
    end
  end
endmodule : ccpt_channel
`default_nettype wire

// File: logic/ccpt_top.sv
// Two capture/compare/PWM channels, shared counter and period timer.
//
// Contract
// - Pre-postscaler period match feeds serial port clock.
// - Postscale field bits 6-3 divides value+1.
// - Control register top bit reads zero.
// - Each channel has one 16-bit multipurpose register.
// - Channel register split into low, high bytes.
// - Channel one trigger clears shared counter.
// - Channel two trigger clears counter, starts conversion.
// - Capture/compare use shared counter; PWM period timer.
// - Both PWMs share period, rising edges aligned.
// - Control bits 5-4 are PWM duty LSBs.
// - Mode 0000 disables and resets the channel.
// - Capture modes: fall, rise, 4th, 16th rise.
// - Compare 1000 sets, 1001 clears pin, flags.
// - Compare 1010 only flags, pin unchanged.
// - Compare 1011 flags and emits special trigger.
// - Capture copies shared counter into channel register.
// - Capture sets channel flag; software clears it.
// - Newer capture overwrites unread older value.
// - Driven pin toggled by port write captures.
// - Period timer wraps to zero after limit.
// - Postscaler completion sets period timer flag.
// - Count/control writes clear prescaler and postscaler.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ccpt_top (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // APB slave.
  input wire logic [ccpt_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ccpt_pkg::DATA_W-1:0] pwdata_i,
  output logic [ccpt_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Channel pins, bit 0 is channel one.
  input wire logic [ccpt_pkg::CH_N-1:0] ch_pin_i,
  output logic [ccpt_pkg::CH_N-1:0] ch_pin_o,
  output logic [ccpt_pkg::CH_N-1:0] ch_pin_oe_n_o,
  // Neighbouring peripherals.
  input wire logic adc_enable_i,
  output logic adc_start_o,
  output logic serial_clk_tick_o
);
  import ccpt_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [7:0] rd_byte;
  logic rd_hit;

  wire [IDX_W-1:0] idx = paddr_i[IDX_LSB+IDX_W-1:IDX_LSB];
  wire addr_ok = (paddr_i[ADDR_W-1:IDX_LSB+IDX_W] == '0) &&
    (paddr_i[IDX_LSB-1:0] == '0);
  wire setup = psel_i & ~penable_i & ~pready_reg;
  wire wr = psel_i & penable_i & pready_reg & pwrite_i & ~pslverr_reg;
  wire [7:0] wd = pwdata_i[7:0];
  wire wr_flags1 = wr & (idx == IDX_FLAGS1);
  wire wr_flags2 = wr & (idx == IDX_FLAGS2);
  wire wr_cnt_l = wr & (idx == IDX_CNT_L);
  wire wr_cnt_h = wr & (idx == IDX_CNT_H);
  wire wr_pcount = wr & (idx == IDX_PCOUNT);
  wire wr_pctrl = wr & (idx == IDX_PCTRL);
  wire wr_limit = wr & (idx == IDX_LIMIT);
  wire wr_ena1 = wr & (idx == IDX_ENA1);
  wire wr_ena2 = wr & (idx == IDX_ENA2);
  wire wr_pdata = wr & (idx == IDX_PORT_DATA);
  wire wr_pdir = wr & (idx == IDX_PORT_DIR);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic ch1_flag_reg;
  logic ch2_flag_reg;
  logic tmr_flag_reg;
  logic [7:0] ena1_reg;
  logic ena2_reg;
  logic [7:0] port_data_reg;
  logic [7:0] port_dir_reg;
  logic [7:0] pcount_reg;
  logic [PCTRL_W-1:0] pctrl_reg;
  logic [7:0] limit_reg;
  logic [3:0] pre_cnt_reg;
  logic [3:0] post_cnt_reg;
  logic [CNT_W-1:0] shared_cnt_reg;
  logic [CH_N-1:0] pin_reg;
  logic [CH_N-1:0] oe_n_reg;
  logic adc_start_reg;
  logic serial_tick_reg;

  wire [CH_N-1:0] cap_bus;
  wire [CH_N-1:0] hit_bus;
  wire [CH_N-1:0] trg_bus;
  wire [CH_N-1:0] pin_next;
  wire [CH_N*CNT_W-1:0] val_bus;
  wire [CH_N*CTRL_W-1:0] ctl_bus;

  // ----------------------------------------------------------------
  // Period timer
  // ----------------------------------------------------------------
  wire run = pctrl_reg[RUN_BIT];
  wire [1:0] ckps = pctrl_reg[CKPS_MSB:CKPS_LSB];
  wire [3:0] ps_field = pctrl_reg[PS_MSB:PS_LSB];
  wire [3:0] pre_m1 = (ckps == CKPS_DIV1) ? PRE_DIV1_M1 :
    (ckps == CKPS_DIV4) ? PRE_DIV4_M1 : PRE_DIV16_M1;
  wire pre_tick = run & (pre_cnt_reg == pre_m1);
  wire ptmr_match = pre_tick & (pcount_reg == limit_reg);
  wire post_done = ptmr_match & (post_cnt_reg == ps_field);
  wire scaler_clr = wr_pcount | wr_pctrl;
  wire [9:0] pwm_pos = {pcount_reg, pre_cnt_reg[1:0]};

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      pcount_reg <= '0;
      pre_cnt_reg <= '0;
      post_cnt_reg <= '0;
    end
    else
    begin
      if (wr_pcount)
        pcount_reg <= wd;
      else if (ptmr_match)
        pcount_reg <= '0;
      else if (pre_tick)
        pcount_reg <= pcount_reg + 8'h01;
      if (scaler_clr || pre_tick)
        pre_cnt_reg <= '0;
      else if (run)
        pre_cnt_reg <= pre_cnt_reg + 4'h1;
      if (scaler_clr || post_done)
        post_cnt_reg <= '0;
      else if (ptmr_match)
        post_cnt_reg <= post_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Shared 16-bit counter
  // ----------------------------------------------------------------
  // A bus write beats a special event trigger in the same cycle.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      shared_cnt_reg <= '0;
    else if (wr_cnt_l)
      shared_cnt_reg <= {shared_cnt_reg[CNT_W-1:8], wd};
    else if (wr_cnt_h)
      shared_cnt_reg <= {wd, shared_cnt_reg[7:0]};
    else if (|trg_bus)
      shared_cnt_reg <= '0;
    else
      shared_cnt_reg <= shared_cnt_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar g;
  for (g = 0; g < CH_N; g++)
  begin : g_ch
    localparam logic [7:0] IL = (g == 0) ? IDX_V1L : IDX_V2L;
    localparam logic [7:0] IH = (g == 0) ? IDX_V1H : IDX_V2H;
    localparam logic [7:0] IC = (g == 0) ? IDX_C1 : IDX_C2;
    localparam int PB = (g == 0) ? PIN_CH1 : PIN_CH2;
    logic sync1_reg;
    logic sync2_reg;
    logic [CNT_W-1:0] val_reg;
    logic [CTRL_W-1:0] ctl_reg;
    logic dout;
    wire [3:0] mode = ctl_reg[MODE_MSB:MODE_LSB];
    wire [9:0] duty = {val_reg[7:0], ctl_reg[DUTY_MSB:DUTY_LSB]};
    // With the pin driven, the channel sees its own output level.
    wire src = port_dir_reg[PB] ? sync2_reg : pin_reg[g];
    wire own = (mode == CMP_SET) || (mode == CMP_CLR) ||
      (mode[3:2] == GRP_PWM);

    always_ff @(posedge ref_clk_i)
    begin
      if (sys_rst_i)
      begin
        sync1_reg <= 1'b0;
        sync2_reg <= 1'b0;
      end
      else
      begin
        sync1_reg <= ch_pin_i[g];
        sync2_reg <= sync1_reg;
      end
    end

    always_ff @(posedge ref_clk_i)
    begin
      if (sys_rst_i)
      begin
        val_reg <= '0;
        ctl_reg <= '0;
      end
      else
      begin
        if (cap_bus[g])
          val_reg <= shared_cnt_reg;
        else if (wr && idx == IL)
          val_reg <= {val_reg[CNT_W-1:8], wd};
        else if (wr && idx == IH)
          val_reg <= {wd, val_reg[7:0]};
        if (wr && idx == IC)
          ctl_reg <= wd[CTRL_W-1:0];
      end
    end

    // Capture and compare use the shared counter, PWM the period timer.
    ccpt_channel u_ch (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .mode_i(mode),
      .duty_i(duty),
      .value_i(val_reg),
      .count_i(shared_cnt_reg),
      .evt_lvl_i(src),
      .pwm_start_i(ptmr_match),
      .pwm_pos_i(pwm_pos),
      .capture_o(cap_bus[g]),
      .match_o(hit_bus[g]),
      .trig_o(trg_bus[g]),
      .out_o(dout)
    );

    assign pin_next[g] = own ? dout : port_data_reg[PB];
    assign val_bus[g*CNT_W +: CNT_W] = val_reg;
    assign ctl_bus[g*CTRL_W +: CTRL_W] = ctl_reg;
  end

  // ----------------------------------------------------------------
  // Flags, enables, port and outputs
  // ----------------------------------------------------------------
  // Hardware sets win over a software clear in the same cycle.
  wire ch1_set = cap_bus[0] | hit_bus[0];
  wire ch2_set = cap_bus[1] | hit_bus[1];

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      ch1_flag_reg <= 1'b0;
      ch2_flag_reg <= 1'b0;
      tmr_flag_reg <= 1'b0;
      ena1_reg <= '0;
      ena2_reg <= 1'b0;
      port_data_reg <= '0;
      port_dir_reg <= DIR_RST;
      pctrl_reg <= '0;
      limit_reg <= LIMIT_RST;
    end
    else
    begin
      ch1_flag_reg <= (wr_flags1 ? wd[FLG_CH1] : ch1_flag_reg) | ch1_set;
      tmr_flag_reg <= (wr_flags1 ? wd[FLG_TMR] : tmr_flag_reg) | post_done;
      ch2_flag_reg <= (wr_flags2 ? wd[FLG_CH2] : ch2_flag_reg) | ch2_set;
      if (wr_ena1)
        ena1_reg <= wd;
      if (wr_ena2)
        ena2_reg <= wd[FLG_CH2];
      if (wr_pdata)
        port_data_reg <= wd;
      if (wr_pdir)
        port_dir_reg <= wd;
      if (wr_pctrl)
        pctrl_reg <= wd[PCTRL_W-1:0];
      if (wr_limit)
        limit_reg <= wd;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_reg <= '0;
      oe_n_reg <= '1;
      adc_start_reg <= 1'b0;
      serial_tick_reg <= 1'b0;
    end
    else
    begin
      pin_reg <= pin_next;
      oe_n_reg <= {port_dir_reg[PIN_CH2], port_dir_reg[PIN_CH1]};
      adc_start_reg <= trg_bus[1] & adc_enable_i;
      serial_tick_reg <= ptmr_match;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_byte = '0;
    rd_hit = addr_ok;
    case (idx)
      IDX_FLAGS1:
      begin
        rd_byte[FLG_CH1] = ch1_flag_reg;
        rd_byte[FLG_TMR] = tmr_flag_reg;
      end
      IDX_FLAGS2: rd_byte[FLG_CH2] = ch2_flag_reg;
      IDX_CNT_L: rd_byte = shared_cnt_reg[7:0];
      IDX_CNT_H: rd_byte = shared_cnt_reg[CNT_W-1:8];
      IDX_PCOUNT: rd_byte = pcount_reg;
      IDX_PCTRL: rd_byte = {1'b0, pctrl_reg};
      IDX_V1L: rd_byte = val_bus[7:0];
      IDX_V1H: rd_byte = val_bus[CNT_W-1:8];
      IDX_C1: rd_byte = {2'b00, ctl_bus[CTRL_W-1:0]};
      IDX_V2L: rd_byte = val_bus[CNT_W+7:CNT_W];
      IDX_V2H: rd_byte = val_bus[2*CNT_W-1:CNT_W+8];
      IDX_C2: rd_byte = {2'b00, ctl_bus[2*CTRL_W-1:CTRL_W]};
      IDX_PORT_DATA: rd_byte = port_data_reg;
      IDX_PORT_DIR: rd_byte = port_dir_reg;
      IDX_ENA1: rd_byte = ena1_reg;
      IDX_ENA2: rd_byte[FLG_CH2] = ena2_reg;
      IDX_LIMIT: rd_byte = limit_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data is sampled in the setup cycle and held for the access.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup;
      if (setup)
      begin
        prdata_reg <= (rd_hit && !pwrite_i) ? {24'h00_0000, rd_byte} : '0;
        pslverr_reg <= ~rd_hit;
      end
      else if (pready_reg)
        pslverr_reg <= 1'b0;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign ch_pin_o = pin_reg;
  assign ch_pin_oe_n_o = oe_n_reg;
  assign adc_start_o = adc_start_reg;
  assign serial_clk_tick_o = serial_tick_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_ctrl_top_zero;
    setup && !pwrite_i && idx == IDX_PCTRL && addr_ok |=> !prdata_reg[7];
  endproperty
  a_ctrl_top_zero: assert property (p_ctrl_top_zero)
    else $error("control top bit read back as one");

  property p_wrap;
    ptmr_match && !wr_pcount |=> pcount_reg == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("period timer did not wrap to zero");

  property p_halt;
    !run && !wr_pcount |=> $stable(pcount_reg);
  endproperty
  a_halt: assert property (p_halt)
    else $error("period timer moved while halted");

  property p_post_flag;
    post_done |=> tmr_flag_reg;
  endproperty
  a_post_flag: assert property (p_post_flag)
    else $error("period flag not set by postscaler");

  property p_serial_tick;
    ptmr_match |=> serial_tick_reg ##1 !serial_tick_reg || $past(ptmr_match);
  endproperty
  a_serial_tick: assert property (p_serial_tick)
    else $error("serial tick does not follow period match");

  property p_trig_clear;
    (|trg_bus) && !wr_cnt_l && !wr_cnt_h |=> shared_cnt_reg == '0;
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("trigger did not clear shared counter");

  property p_adc_start;
    trg_bus[1] && adc_enable_i |=> adc_start_o;
  endproperty
  a_adc_start: assert property (p_adc_start)
    else $error("conversion start missing after trigger");

  property p_capture_value;
    cap_bus[0] |=> val_bus[CNT_W-1:0] == $past(shared_cnt_reg) && ch1_flag_reg;
  endproperty
  a_capture_value: assert property (p_capture_value)
    else $error("capture value or flag wrong");

  property p_scaler_clear;
    wr_pctrl |=> pre_cnt_reg == '0 && post_cnt_reg == '0;
  endproperty
  a_scaler_clear: assert property (p_scaler_clear)
    else $error("scalers not cleared by control write");
endmodule : ccpt_top
`default_nettype wire

// File: tb/ccpt_pin_model.sv
// Far-side model of the two channel pins.
`timescale 1ns/1ps
`default_nettype none
module ccpt_pin_model (
  // Level put on each pin by the outside source.
  input wire logic [1:0] ext_lvl_i,
  // Drive from the block.
  input wire logic [1:0] pin_o_i,
  input wire logic [1:0] oe_n_i,
  // Resolved wire level.
  output logic [1:0] wire_o
);
  // A driven pin shows its own drive, so a port write can cause a capture.
  assign wire_o = (oe_n_i & ext_lvl_i) | (~oe_n_i & pin_o_i);
endmodule : ccpt_pin_model
`default_nettype wire

// File: tb/tb_ccpt_top.sv
// Self-checking bench for the capture/compare block.
`timescale 1ns/1ps
`default_nettype none
module tb_ccpt_top;
  import ccpt_pkg::*;
  logic ref_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [11:0] paddr = '0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic adc_en = 1'h0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic adc_start;
  logic tick;
  logic [1:0] ext_lvl = '0;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] oe_n;
  logic [31:0] r;
  logic e;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  ccpt_top ccpt_top_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ch_pin_i(pin_in), .ch_pin_o(pin_out),
    .ch_pin_oe_n_o(oe_n), .adc_enable_i(adc_en), .adc_start_o(adc_start),
    .serial_clk_tick_o(tick));
  ccpt_pin_model ccpt_pin_model_i (.ext_lvl_i(ext_lvl), .pin_o_i(pin_out), .oe_n_i(oe_n),
    .wire_o(pin_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'h1;
    paddr <= a;
    pwr <= w;
    pwdata <= d;
    @(posedge ref_clk_i);
    pen <= 1'h1;
    do @(posedge ref_clk_i); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(ad(i), 1'h1, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [7:0] i);
    apb(ad(i), 1'h0, '0);
  endtask : rd
  task automatic rdv(input logic [7:0] i, output logic [15:0] v);
    rd(i);
    v[7:0] = r[7:0];
    rd(i + 8'h01);
    v[15:8] = r[7:0];
  endtask : rdv
  // Waits for tick (0) or the converter start (3), at most lim cycles.
  task automatic wt(input int s, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (((s == 0) ? tick : adc_start) !== 1'h1 && n < lim);
  endtask : wt
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(IDX_LIMIT);
    chk(r, {24'h0, LIMIT_RST});
    rd(IDX_PORT_DIR);
    chk(r, {24'h0, DIR_RST});
    apb(12'h3fc, 1'h0, '0);
    chk(e, 1'h1);
    wr(IDX_PCTRL, 8'hff);
    rd(IDX_PCTRL);
    chk(r, 32'h0000_007f);
  endtask : t_reset
  task automatic t_period;
    int n;
    wr(IDX_LIMIT, 8'h03);
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_PCTRL, 8'h04 | k[7:0]);
      wt(0, 300, n);
      wt(0, 300, n);
      chk(n, 4 * ((k == 0) ? 1 : (k == 1) ? 4 : 16));
    end
    wr(IDX_PCTRL, 8'h78);
    wr(IDX_FLAGS1, 8'h00);
    wr(IDX_PCTRL, 8'h7c);
    repeat (40) @(posedge ref_clk_i);
    rd(IDX_FLAGS1);
    chk(r[FLG_TMR], 1'h0);
    repeat (40) @(posedge ref_clk_i);
    rd(IDX_FLAGS1);
    chk(r[FLG_TMR], 1'h1);
    wr(IDX_PCTRL, 8'h00);
    // A tick launched in the last running cycle may still be in flight.
    @(posedge ref_clk_i);
    wt(0, 100, n);
    chk(n, 100);
  endtask : t_period
  task automatic t_capture;
    logic [15:0] v1;
    logic [15:0] v2;
    wr(IDX_C1, 8'h05);
    wr(IDX_C2, 8'h05);
    wr(IDX_FLAGS1, 8'h00);
    ext_lvl <= 2'h1;
    repeat (20) @(posedge ref_clk_i);
    ext_lvl <= 2'h3;
    repeat (15) @(posedge ref_clk_i);
    ext_lvl <= 2'h2;
    repeat (15) @(posedge ref_clk_i);
    ext_lvl <= 2'h3;
    repeat (5) @(posedge ref_clk_i);
    rdv(IDX_V1L, v1);
    rdv(IDX_V2L, v2);
    chk(v1 - v2, 16'h001e);
    rd(IDX_FLAGS2);
    chk(r[FLG_CH2], 1'h1);
    rd(IDX_FLAGS1);
    chk(r[FLG_CH1], 1'h1);
    wr(IDX_FLAGS1, 8'h00);
    rd(IDX_FLAGS1);
    chk(r[FLG_CH1], 1'h0);
  endtask : t_capture
  task automatic t_prescale(input logic [3:0] m, input int cnt);
    logic [15:0] v1;
    logic [15:0] v2;
    wr(IDX_C1, MODE_OFF);
    wr(IDX_C1, {4'h0, m});
    wr(IDX_C2, {4'h0, CAP_FALL});
    for (int i = 1; i <= cnt + 1; i++)
    begin
      ext_lvl[0] <= 1'h0;
      repeat (8) @(posedge ref_clk_i);
      ext_lvl[0] <= 1'h1;
      if (i == cnt)
        ext_lvl[1] <= 1'h0;
      repeat (8) @(posedge ref_clk_i);
    end
    rdv(IDX_V1L, v1);
    rdv(IDX_V2L, v2);
    chk(v1, v2);
    ext_lvl[1] <= 1'h1;
  endtask : t_prescale
  // Arms a channel one compare at 0x40 and checks the pin and flag.
  task automatic cmp(input logic [3:0] m, input logic lvl);
    wr(IDX_FLAGS1, 8'h00);
    wr(IDX_C1, {4'h0, m});
    wr(IDX_CNT_H, 8'h00);
    wr(IDX_CNT_L, 8'h00);
    repeat (100) @(posedge ref_clk_i);
    chk(pin_out[0], lvl);
    rd(IDX_FLAGS1);
    chk(r[FLG_CH1], 1'h1);
  endtask : cmp
  task automatic t_compare;
    int n;
    wr(IDX_PORT_DIR, 8'hf9);
    wr(IDX_V1L, 8'h40);
    wr(IDX_V1H, 8'h00);
    cmp(CMP_SET, 1'h1);
    chk(oe_n[0], 1'h0);
    cmp(CMP_CLR, 1'h0);
    cmp(CMP_SET, 1'h1);
    wr(IDX_C1, MODE_OFF);
    wr(IDX_C1, {4'h0, CMP_SET});
    repeat (3) @(posedge ref_clk_i);
    chk(pin_out[0], 1'h0);
    wr(IDX_PORT_DATA, 8'h04);
    cmp(4'ha, 1'h1);
    cmp(CMP_TRIG, 1'h1);
    rd(IDX_CNT_L);
    chk(r[7:0] < 8'h48, 1'h1);
    wr(IDX_C1, MODE_OFF);
    adc_en <= 1'h1;
    wr(IDX_V2L, 8'h20);
    wr(IDX_V2H, 8'h00);
    wr(IDX_C2, CMP_TRIG);
    wr(IDX_CNT_L, 8'h00);
    wt(3, 100, n);
    chk(n < 100, 1'h1);
    rd(IDX_CNT_L);
    chk(r[7:0] < 8'h10, 1'h1);
    adc_en <= 1'h0;
    wr(IDX_CNT_L, 8'h00);
    wt(3, 100, n);
    chk(n, 100);
  endtask : t_compare
  // Both channels in PWM, duties 10 and 5, over three 16-cycle periods.
  task automatic t_pwm;
    int h0 = 0;
    int h1 = 0;
    int skew = 0;
    logic [1:0] p;
    wr(IDX_V1L, 8'h02);
    wr(IDX_C1, 8'h2c);
    wr(IDX_V2L, 8'h01);
    wr(IDX_C2, 8'h1c);
    wr(IDX_PCTRL, 8'h05);
    repeat (24) @(posedge ref_clk_i);
    p = pin_out;
    repeat (48)
    begin
      @(posedge ref_clk_i);
      h0 += pin_out[0];
      h1 += pin_out[1];
      skew += ((pin_out[0] & ~p[0]) != (pin_out[1] & ~p[1]));
      p = pin_out;
    end
    chk(h0 - h1, 15);
    chk(skew, 0);
    wr(IDX_C2, 8'h05);
    wr(IDX_FLAGS2, 8'h00);
    wr(IDX_PORT_DATA, 8'h06);
    repeat (3) @(posedge ref_clk_i);
    rd(IDX_FLAGS2);
    chk(r[FLG_CH2], 1'h1);
  endtask : t_pwm
  task automatic conclude;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'h0;
    t_reset;
    t_period;
    t_capture;
    t_prescale(CAP_4TH, 4);
    t_prescale(CAP_16TH, 16);
    t_compare;
    t_pwm;
    conclude;
  end
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude;
    end
  end
endmodule : tb_ccpt_top
`default_nettype wire
